/* File: hdl/uesc_pkg.sv */
// Constants for the endpoint status and control block.
// Assumes one 25 MHz clock and a classic Wishbone register bus.
`default_nettype none

package uesc_pkg;

  // ==========================================================
  // Register byte offsets on the Wishbone bus
  localparam logic [15:0] OFS_STATUS_WINDOW = 16'h0000;
  localparam logic [15:0] OFS_FLAGS         = 16'h0004;
  localparam logic [15:0] OFS_DEV_ADDR      = 16'h0008;
  localparam logic [15:0] OFS_FRAME_LOW     = 16'h000C;
  localparam logic [15:0] OFS_FRAME_HIGH    = 16'h0010;
  localparam logic [15:0] OFS_EP_CTRL_BASE  = 16'h0040;
  localparam logic [1:0]  RAM_REGION_TAG    = 2'h1;

  // ==========================================================
  // Buffer memory map, in byte addresses of the data space
  localparam logic [11:0] RAM_FIRST  = 12'h060;
  localparam logic [11:0] RAM_LAST   = 12'hF3F;
  localparam logic [11:0] DESC_FIRST = 12'h400;
  localparam logic [11:0] DESC_LAST  = 12'h4FF;
  localparam int          OWN_BIT    = 7;

  // ==========================================================
  // Field positions and reset values
  localparam int          FLAG_DONE_BIT    = 0;
  localparam int          FLAG_BUSRST_BIT  = 1;
  localparam int          FLAG_SUSPEND_BIT = 2;
  localparam int          EPC_HSHK_BIT     = 4;
  localparam int          EPC_CONDIS_BIT   = 3;
  localparam int          EPC_OUTEN_BIT    = 2;
  localparam int          EPC_INEN_BIT     = 1;
  localparam int          EPC_STALL_BIT    = 0;
  localparam logic [4:0]  EP_CTRL_RESET    = 5'h00;
  localparam logic [6:0]  DEV_ADDR_RESET   = 7'h00;
  localparam int          STATUS_DEPTH     = 4;
  localparam int          ENDPOINT_COUNT   = 16;

  // ==========================================================
  // Timing: flag re-raise bound, longest time rounds down
  localparam int CLOCK_NS         = 40;
  localparam int INSTR_CYCLE_NS   = 83;
  localparam int REASSERT_INSTR   = 6;
  localparam int REASSERT_CYCLES  =
    (REASSERT_INSTR * INSTR_CYCLE_NS) / CLOCK_NS;

  // ==========================================================
  // Token kinds and link answers
  typedef enum logic [2:0] {
    PID_OUT   = 3'h1,
    PID_IN    = 3'h2,
    PID_SETUP = 3'h4
  } uesc_pid_type;

  typedef enum logic [4:0] {
    RESP_IGNORE = 5'h01,
    RESP_ACCEPT = 5'h02,
    RESP_NAK    = 5'h04,
    RESP_STALL  = 5'h08,
    RESP_SILENT = 5'h10
  } uesc_resp_type;

endpackage : uesc_pkg

`default_nettype wire

/* File: hdl/uesc_status_queue.sv */
// Transfer status queue, first in first out.
// A push while full is dropped; count holds at DEPTH.
`default_nettype none

module uesc_status_queue #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  // Write side
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  // Read side
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           head,
  output logic      [$clog2(DEPTH):0]     count
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] entry [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             do_push;
  logic             do_pop;

  assign do_push = push && (count != DEPTH[PW:0]);
  assign do_pop  = pop && (count != '0);
  assign head    = entry[rd_ptr];

  // ==========================================================
  // Storage
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      entry[wr_ptr] <= push_data;
    end
  end

  // ==========================================================
  // Pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

endmodule : uesc_status_queue

`default_nettype wire

/* File: hdl/uesc_top.sv */
// Endpoint status and control logic of a USB device engine.
// Assumes a Wishbone master for firmware and an engine front end
// that decodes tokens and reports transfer events in sys_clk.
//
// How it works
// - Status window heads a four-entry queue
// - Finished buffer pushes its status entry
// - Clearing flag pops; re-raised within 12 cycles
// - Empty queue after clear keeps flag low
// - Full queue answers NAK to enabled, unstalled own-address tokens
// - Window bits 6-3 endpoint; 7,0 zero
// - Window bit 2 set for IN
// - Window bit 1 gives odd or even bank
// - Sixteen endpoint control registers, top bits zero
// - Bit 4 enables handshakes for endpoint
// - Bit 3 set rejects SETUP transfers
// - Bit 2 enables OUT, bit 1 IN
// - Issued stall sets sticky stall bit 0
// - Stall bit ignored on disabled endpoint
// - Address clears on bus or device reset
// - Only tokens for own address answered
// - SOF loads 11-bit frame number pair
// - Frame registers read-only, frozen in suspend
// - Buffer memory spans 60h to F3Fh
// - 400h to 4FFh holds descriptor space
// - Engine clears ownership bit on completion
`default_nettype none

module uesc_top #(
  parameter int EP_COUNT  = uesc_pkg::ENDPOINT_COUNT,
  parameter int Q_DEPTH   = uesc_pkg::STATUS_DEPTH
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Token decode from the engine front end
  input  wire logic        tok_valid,
  input  wire logic [6:0]  tok_addr,
  input  wire logic [3:0]  tok_endp,
  input  wire logic [2:0]  tok_pid,
  output logic             resp_valid,
  output logic      [4:0]  resp_code,
  output logic             resp_handshake,
  // Transfer completion and stall events
  input  wire logic        xfer_done,
  input  wire logic [3:0]  xfer_endp,
  input  wire logic        xfer_in,
  input  wire logic        xfer_odd,
  input  wire logic [5:0]  xfer_desc,
  input  wire logic        stall_issued,
  input  wire logic [3:0]  stall_endp,
  // Bus state
  input  wire logic        bus_reset,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_frame,
  input  wire logic        suspend_state,
  // Engine port into buffer memory
  input  wire logic [11:0] eng_ram_addr,
  input  wire logic        eng_ram_we,
  input  wire logic [7:0]  eng_ram_wdata,
  output logic      [7:0]  eng_ram_rdata,
  output logic             eng_ram_ready
);

  localparam int QW = $clog2(Q_DEPTH);
  localparam int REASSERT_MAX = uesc_pkg::REASSERT_CYCLES;
  localparam int OWN_BIT_L    = uesc_pkg::OWN_BIT;

  // ==========================================================
  // State
  logic [4:0]    endpoint_control [EP_COUNT];
  logic [6:0]    device_bus_address;
  logic [7:0]    frame_number_low;
  logic [2:0]    frame_number_high;
  logic          transfer_done_flag;
  logic          bus_reset_flag;
  logic [7:0]    usb_ram [uesc_pkg::RAM_FIRST:uesc_pkg::RAM_LAST];
  logic [5:0]    q_head;
  logic [QW:0]   q_count;
  logic          q_full;
  logic          q_pop;
  logic          q_flush;

  // ==========================================================
  // Bus decode
  logic          wb_req;
  logic          wb_wr;
  logic          is_ram;
  logic [11:0]   ram_idx;
  logic          ram_hit;
  logic          is_ep;
  logic [3:0]    ep_sel;
  logic          ram_wr_req;
  logic          own_clear;
  logic [11:0]   own_idx;
  logic          bus_stall;

  assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
  assign is_ram     = wb_adr_i[15:14] == uesc_pkg::RAM_REGION_TAG;
  assign ram_idx    = wb_adr_i[13:2];
  assign ram_hit    = is_ram && ram_idx >= uesc_pkg::RAM_FIRST
                      && ram_idx <= uesc_pkg::RAM_LAST;
  assign is_ep      = !is_ram && wb_adr_i[15:6] ==
                      uesc_pkg::OFS_EP_CTRL_BASE[15:6]
                      && {1'b0, wb_adr_i[5:2]} < 5'(EP_COUNT);
  assign ep_sel     = wb_adr_i[5:2];
  assign own_clear  = xfer_done;
  assign own_idx    = uesc_pkg::DESC_FIRST + {4'h0, xfer_desc, 2'b00};
  assign ram_wr_req = wb_wr && ram_hit;
  assign eng_ram_ready = !own_clear;
  assign bus_stall  = ram_wr_req && (own_clear || eng_ram_we);
  assign q_flush    = bus_reset;
  assign q_pop      = wb_wr && !bus_stall && !is_ram
                      && wb_adr_i == uesc_pkg::OFS_FLAGS
                      && wb_dat_i[uesc_pkg::FLAG_DONE_BIT]
                      && transfer_done_flag;
  assign q_full     = q_count == (QW+1)'(Q_DEPTH);

  // ==========================================================
  // Status queue
  // Four-entry head window
  uesc_status_queue #(
    .WIDTH (6),
    .DEPTH (Q_DEPTH)
  ) u_queue (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (q_flush),
    .push      (xfer_done),
    .push_data ({xfer_endp, xfer_in, xfer_odd}),
    .pop       (q_pop),
    .head      (q_head),
    .count     (q_count)
  );

  // ==========================================================
  // Transfer done flag
  always_ff @(posedge sys_clk) begin
    if (rst || bus_reset) begin
      transfer_done_flag <= 1'b0;
    end else if (q_pop) begin
      transfer_done_flag <= 1'b0;
    end else if (q_count != '0) begin
      transfer_done_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Bus reset flag, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_reset_flag <= 1'b0;
    end else if (bus_reset) begin
      bus_reset_flag <= 1'b1;
    end else if (wb_wr && !is_ram && wb_adr_i == uesc_pkg::OFS_FLAGS
                 && wb_dat_i[uesc_pkg::FLAG_BUSRST_BIT]) begin
      bus_reset_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Device address
  always_ff @(posedge sys_clk) begin
    if (rst || bus_reset) begin
      device_bus_address <= uesc_pkg::DEV_ADDR_RESET;
    end else if (wb_wr && !is_ram
                 && wb_adr_i == uesc_pkg::OFS_DEV_ADDR) begin
      device_bus_address <= wb_dat_i[6:0];
    end
  end

  // ==========================================================
  // Frame number
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_number_low  <= 8'h00;
      frame_number_high <= 3'h0;
    end else if (sof_valid && !suspend_state) begin
      frame_number_low  <= sof_frame[7:0];
      frame_number_high <= sof_frame[10:8];
    end
  end

  // ==========================================================
  // Endpoint control registers
  genvar gi;
  generate
    for (gi = 0; gi < EP_COUNT; gi++) begin : g_ep
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          endpoint_control[gi] <= uesc_pkg::EP_CTRL_RESET;
        end else begin
          if (wb_wr && is_ep && ep_sel == 4'(gi)) begin
            endpoint_control[gi] <= wb_dat_i[4:0];
          end
          if (stall_issued && stall_endp == 4'(gi)) begin
            endpoint_control[gi][uesc_pkg::EPC_STALL_BIT] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Token answer
  logic [4:0]          tok_ctrl;
  logic                tok_ep_on;
  logic                tok_dir_ok;
  uesc_pkg::uesc_resp_type next_resp;

  assign tok_ctrl  = endpoint_control[tok_endp];
  assign tok_ep_on = tok_ctrl[uesc_pkg::EPC_OUTEN_BIT]
                     || tok_ctrl[uesc_pkg::EPC_INEN_BIT];

  always_comb begin
    tok_dir_ok = 1'b0;
    unique case (tok_pid)
      uesc_pkg::PID_OUT:   tok_dir_ok = tok_ctrl[uesc_pkg::EPC_OUTEN_BIT];
      uesc_pkg::PID_IN:    tok_dir_ok = tok_ctrl[uesc_pkg::EPC_INEN_BIT];
      uesc_pkg::PID_SETUP: tok_dir_ok =
        tok_ctrl[uesc_pkg::EPC_OUTEN_BIT]
        && tok_ctrl[uesc_pkg::EPC_INEN_BIT]
        && !tok_ctrl[uesc_pkg::EPC_CONDIS_BIT];
      default:             tok_dir_ok = 1'b0;
    endcase
  end

  always_comb begin
    if (tok_addr != device_bus_address || !tok_dir_ok) begin
      next_resp = uesc_pkg::RESP_IGNORE;
    end else if (tok_ep_on && tok_ctrl[uesc_pkg::EPC_STALL_BIT]) begin
      next_resp = uesc_pkg::RESP_STALL;
    end else if (q_full) begin
      next_resp = uesc_pkg::RESP_NAK;
    end else if (!tok_ctrl[uesc_pkg::EPC_HSHK_BIT]) begin
      next_resp = uesc_pkg::RESP_SILENT;
    end else begin
      next_resp = uesc_pkg::RESP_ACCEPT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_valid     <= 1'b0;
      resp_code      <= uesc_pkg::RESP_IGNORE;
      resp_handshake <= 1'b0;
    end else begin
      resp_valid <= tok_valid;
      if (tok_valid) begin
        resp_code      <= next_resp;
        resp_handshake <= tok_ctrl[uesc_pkg::EPC_HSHK_BIT];
      end
    end
  end

  // ==========================================================
  // Buffer memory, one write port
  always_ff @(posedge sys_clk) begin
    if (own_clear) begin
      usb_ram[own_idx][OWN_BIT_L] <= 1'b0;
    end else if (eng_ram_we && eng_ram_addr >= uesc_pkg::RAM_FIRST
                 && eng_ram_addr <= uesc_pkg::RAM_LAST) begin
      usb_ram[eng_ram_addr] <= eng_ram_wdata;
    end else if (ram_wr_req) begin
      usb_ram[ram_idx] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eng_ram_rdata <= 8'h00;
    end else if (eng_ram_addr >= uesc_pkg::RAM_FIRST
                 && eng_ram_addr <= uesc_pkg::RAM_LAST) begin
      eng_ram_rdata <= usb_ram[eng_ram_addr];
    end else begin
      eng_ram_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Wishbone answer and read data
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (is_ram) begin
      rd_byte = ram_hit ? usb_ram[ram_idx] : 8'h00;
    end else if (is_ep) begin
      rd_byte = {3'h0, endpoint_control[ep_sel]};
    end else begin
      unique case (wb_adr_i)
        uesc_pkg::OFS_STATUS_WINDOW: rd_byte = {1'b0, q_head, 1'b0};
        uesc_pkg::OFS_FLAGS:         rd_byte = {5'h00, suspend_state,
                                                bus_reset_flag,
                                                transfer_done_flag};
        uesc_pkg::OFS_DEV_ADDR:      rd_byte = {1'b0, device_bus_address};
        uesc_pkg::OFS_FRAME_LOW:     rd_byte = frame_number_low;
        uesc_pkg::OFS_FRAME_HIGH:    rd_byte = {5'h00, frame_number_high};
        default:                     rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req && !bus_stall;
      if (wb_req && !bus_stall) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================
  // Checks
  AST_REASSERT: assert property (
    @(posedge sys_clk) disable iff (rst)
    (q_pop && q_count > (QW+1)'(1) && !bus_reset)
      |=> ##[0:REASSERT_MAX] transfer_done_flag)
    else $error("flag not raised again after clear");

  AST_STAYS_CLEAR: assert property (
    @(posedge sys_clk) disable iff (rst)
    (q_pop && q_count == (QW+1)'(1) && !xfer_done)
      |=> !transfer_done_flag [*2])
    else $error("flag rose with an empty queue");

  AST_NAK_FULL: assert property (
    @(posedge sys_clk) disable iff (rst)
    (tok_valid && q_full && tok_addr == device_bus_address
     && tok_dir_ok && !tok_ctrl[uesc_pkg::EPC_STALL_BIT])
      |=> resp_valid && resp_code == uesc_pkg::RESP_NAK)
    else $error("full queue did not answer NAK");

  AST_PUSH: assert property (
    @(posedge sys_clk) disable iff (rst)
    (xfer_done && !q_full && !q_pop && !bus_reset)
      |=> q_count == $past(q_count) + (QW+1)'(1))
    else $error("transfer status not queued");

  AST_ADDR_RESET: assert property (
    @(posedge sys_clk) disable iff (rst)
    bus_reset |=> device_bus_address == 7'h00 && bus_reset_flag)
    else $error("address not cleared by bus reset");

  AST_FRAME: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sof_valid && !suspend_state)
      |=> {frame_number_high, frame_number_low} == $past(sof_frame))
    else $error("frame number not loaded");

  AST_STALL_SET: assert property (
    @(posedge sys_clk) disable iff (rst)
    stall_issued
      |=> endpoint_control[$past(stall_endp)][uesc_pkg::EPC_STALL_BIT])
    else $error("stall bit not set");

  AST_WRONG_ADDR: assert property (
    @(posedge sys_clk) disable iff (rst)
    (tok_valid && tok_addr != device_bus_address)
      |=> resp_code == uesc_pkg::RESP_IGNORE)
    else $error("token for another address answered");

  AST_FLUSH: assert property (
    @(posedge sys_clk) disable iff (rst)
    bus_reset |=> q_count == '0 && !transfer_done_flag)
    else $error("queue not emptied by bus reset");

  AST_WINDOW_ZERO: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wb_ack_o && !wb_we_i && wb_adr_i == uesc_pkg::OFS_STATUS_WINDOW)
      |-> wb_dat_o[7] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("status window reserved bits set");

endmodule : uesc_top

`default_nettype wire

/* File: sim/uesc_host_model.sv */
// Host and engine front end model: tokens, events, SOF, memory.
// Assumes sys_clk from the bench; the bench calls its tasks.
`default_nettype none

module uesc_host_model (
  // Clock and answer
  input  wire logic        sys_clk,
  input  wire logic        resp_valid,
  input  wire logic [4:0]  resp_code,
  input  wire logic [7:0]  eng_ram_rdata,
  // Tokens
  output logic             tok_valid,
  output logic      [6:0]  tok_addr,
  output logic      [3:0]  tok_endp,
  output logic      [2:0]  tok_pid,
  // Events
  output logic             xfer_done,
  output logic      [3:0]  xfer_endp,
  output logic             xfer_in,
  output logic             xfer_odd,
  output logic      [5:0]  xfer_desc,
  output logic             stall_issued,
  output logic      [3:0]  stall_endp,
  // Bus state
  output logic             bus_reset,
  output logic             sof_valid,
  output logic      [10:0] sof_frame,
  output logic             suspend_state,
  // Engine memory port
  output logic      [11:0] eng_ram_addr,
  output logic             eng_ram_we,
  output logic      [7:0]  eng_ram_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {tok_valid, tok_addr, tok_endp, tok_pid} = '0;
    {xfer_done, xfer_endp, xfer_in, xfer_odd, xfer_desc} = '0;
    {stall_issued, stall_endp, bus_reset, sof_valid} = '0;
    {sof_frame, suspend_state} = '0;
    {eng_ram_addr, eng_ram_we, eng_ram_wdata} = '0;
  end

  // ==========================================================
  // Token, answer sampled just after the cycle it stands
  // host picks address
  task automatic token(input logic [6:0] a, input logic [3:0] e,
                       input logic [2:0] p, output logic [4:0] c);
    @(posedge sys_clk);
    tok_valid <= 1'b1;
    {tok_addr, tok_endp, tok_pid} <= {a, e, p};
    @(posedge sys_clk);
    tok_valid <= 1'b0;
    {tok_addr, tok_endp, tok_pid} <= ~{a, e, p};
    #1;
    c = (resp_valid === 1'b1) ? resp_code : 5'h00;
  endtask : token

  // ==========================================================
  // Events
  // completion returns ownership
  task automatic xfer(input logic [3:0] e, input logic i,
                      input logic o, input logic [5:0] d);
    @(posedge sys_clk);
    xfer_done <= 1'b1;
    {xfer_endp, xfer_in, xfer_odd, xfer_desc} <= {e, i, o, d};
    @(posedge sys_clk);
    xfer_done <= 1'b0;
    {xfer_endp, xfer_in, xfer_odd, xfer_desc} <= ~{e, i, o, d};
  endtask : xfer

  task automatic stall(input logic [3:0] e);
    @(posedge sys_clk);
    {stall_issued, stall_endp} <= {1'b1, e};
    @(posedge sys_clk);
    {stall_issued, stall_endp} <= {1'b0, ~e};
  endtask : stall

  task automatic sof(input logic [10:0] f);
    @(posedge sys_clk);
    {sof_valid, sof_frame} <= {1'b1, f};
    @(posedge sys_clk);
    {sof_valid, sof_frame} <= {1'b0, ~f};
  endtask : sof

  task automatic busrst();
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
  endtask : busrst

  task automatic suspend(input logic s);
    @(posedge sys_clk);
    suspend_state <= s;
  endtask : suspend

  task automatic eng_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {eng_ram_addr, eng_ram_we, eng_ram_wdata} <= {a, 1'b1, d};
    @(posedge sys_clk);
    {eng_ram_addr, eng_ram_we, eng_ram_wdata} <= {~a, 1'b0, ~d};
  endtask : eng_wr

  task automatic eng_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    eng_ram_addr <= a;
    @(posedge sys_clk);
    #1;
    d = eng_ram_rdata;
  endtask : eng_rd
endmodule : uesc_host_model

`default_nettype wire

/* File: sim/uesc_top_tb_top.sv */
// Bench for the endpoint status and control block.
// Assumes the design package is compiled first.
`default_nettype none

module uesc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i, tok_endp, xfer_endp, stall_endp;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        tok_valid, resp_valid, resp_handshake, xfer_done;
  logic        xfer_in, xfer_odd, stall_issued, bus_reset, sof_valid;
  logic        suspend_state, eng_ram_we, eng_ram_ready;
  logic [6:0]  tok_addr;
  logic [2:0]  tok_pid;
  logic [4:0]  resp_code, c;
  logic [5:0]  xfer_desc;
  logic [10:0] sof_frame;
  logic [11:0] eng_ram_addr;
  logic [7:0]  eng_ram_wdata, eng_ram_rdata;
  int          n_fail, checks_done, k;
  localparam logic [15:0] EP = uesc_pkg::OFS_EP_CTRL_BASE + 16'h0004;
  localparam logic [15:0] FL = uesc_pkg::OFS_FLAGS;
  localparam logic [15:0] AD = uesc_pkg::OFS_DEV_ADDR;
  localparam logic [15:0] FLO = uesc_pkg::OFS_FRAME_LOW;
  localparam logic [15:0] SW = uesc_pkg::OFS_STATUS_WINDOW;
  logic [7:0]  d8;
  logic [7:0]  tc [7] = '{8'h16, 8'h16, 8'h1E, 8'h1E, 8'h06, 8'h12, 8'h14};
  logic [2:0]  tp [7] = '{3'h1, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
  logic [4:0]  tr [7] = '{5'h02, 5'h02, 5'h01, 5'h02, 5'h10, 5'h01, 5'h02};
  logic [3:0]  xe [4] = '{4'hF, 4'h0, 4'h9, 4'h6};
  logic        xi [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic        xo [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  uesc_top uesc_top_inst (
    .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tok_valid, .tok_addr,
    .tok_endp, .tok_pid, .resp_valid, .resp_code, .resp_handshake,
    .xfer_done, .xfer_endp, .xfer_in, .xfer_odd, .xfer_desc,
    .stall_issued, .stall_endp, .bus_reset, .sof_valid, .sof_frame,
    .suspend_state, .eng_ram_addr, .eng_ram_we, .eng_ram_wdata,
    .eng_ram_rdata, .eng_ram_ready
  );

  uesc_host_model uesc_host_model_inst (
    .sys_clk, .resp_valid, .resp_code, .tok_valid, .tok_addr, .tok_endp,
    .tok_pid, .xfer_done, .xfer_endp, .xfer_in, .xfer_odd, .xfer_desc,
    .stall_issued, .stall_endp, .bus_reset, .sof_valid, .sof_frame,
    .suspend_state, .eng_ram_addr, .eng_ram_we, .eng_ram_wdata,
    .eng_ram_rdata
  );

  // ==========================================================
  // Clock, compare, bus cycles
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    q = wb_dat_o;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, {24'h0, d}, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask : rd

  function automatic logic [15:0] mem(input logic [11:0] a);
    return 16'h4000 + {2'h0, a, 2'h0};
  endfunction : mem

  // ==========================================================
  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(uesc_pkg::OFS_EP_CTRL_BASE + 16'h000C, 8'h00);
    rd(AD, 8'h00);
    rd(FL, 8'h00);
    wr(EP, 8'hFF);
    rd(EP, 8'h1F);
    wr(FLO, 8'hFF);
    rd(FLO, 8'h00);
    wr(16'h0020, 8'hFF);
    rd(16'h0020, 8'h00);
    wr(AD, 8'h05);
    rd(AD, 8'h05);
    $display("test registers done");
    for (k = 0; k < 7; k++) begin
      wr(EP, tc[k]);
      uesc_host_model_inst.token(7'h05, 4'h1, tp[k], c);
      chk({27'h0, c}, {27'h0, tr[k]});
      chk({31'h0, resp_handshake}, {31'h0, tc[k][4]});
    end
    wr(uesc_pkg::OFS_EP_CTRL_BASE, 8'h16);
    uesc_host_model_inst.token(7'h05, 4'h0, 3'h4, c);
    chk({27'h0, c}, 32'h02);
    wr(EP, 8'h16);
    uesc_host_model_inst.token(7'h06, 4'h1, 3'h2, c);
    chk({27'h0, c}, 32'h01);
    uesc_host_model_inst.stall(4'h1);
    rd(EP, 8'h17);
    uesc_host_model_inst.token(7'h05, 4'h1, 3'h2, c);
    chk({27'h0, c}, 32'h08);
    wr(EP, 8'h11);
    uesc_host_model_inst.token(7'h05, 4'h1, 3'h2, c);
    chk({27'h0, c}, 32'h01);
    wr(EP, 8'h16);
    rd(EP, 8'h16);
    $display("test tokens done");
    wr(mem(12'h408), 8'h80);
    for (k = 0; k < 4; k++) begin
      uesc_host_model_inst.xfer(xe[k], xi[k], xo[k], 6'(k + 2));
    end
    rd(mem(12'h408), 8'h00);
    rd(FL, 8'h01);
    uesc_host_model_inst.token(7'h05, 4'h1, 3'h1, c);
    chk({27'h0, c}, 32'h04);
    for (k = 0; k < 4; k++) begin
      rd(SW, {1'b0, xe[k], xi[k], xo[k], 1'b0});
      wr(FL, 8'h01);
      rd(FL, (k < 3) ? 8'h01 : 8'h00);
    end
    uesc_host_model_inst.token(7'h05, 4'h1, 3'h1, c);
    chk({27'h0, c}, 32'h02);
    $display("test queue done");
    uesc_host_model_inst.sof(11'h5A3);
    rd(FLO, 8'hA3);
    rd(uesc_pkg::OFS_FRAME_HIGH, 8'h05);
    uesc_host_model_inst.suspend(1'b1);
    uesc_host_model_inst.sof(11'h123);
    rd(FLO, 8'hA3);
    uesc_host_model_inst.suspend(1'b0);
    uesc_host_model_inst.xfer(4'h2, 1'b0, 1'b0, 6'h03);
    uesc_host_model_inst.busrst();
    rd(FL, 8'h02);
    rd(AD, 8'h00);
    rd(EP, 8'h16);
    wr(FL, 8'h02);
    rd(FL, 8'h00);
    $display("test frame and bus reset done");
    wr(mem(12'h100), 8'hA5);
    rd(mem(12'h100), 8'hA5);
    uesc_host_model_inst.eng_wr(12'h200, 8'h3C);
    rd(mem(12'h200), 8'h3C);
    uesc_host_model_inst.eng_rd(12'h100, d8);
    chk({24'h0, d8}, 32'hA5);
    chk({31'h0, eng_ram_ready}, 32'h1);
    rd(mem(12'h050), 8'h00);
    $display("test memory done");
    stop_test();
  end
endmodule : uesc_top_tb_top

`default_nettype wire
